// File: bench/test_mma_memory_addressing.sv
`timescale 1ns/1ps

module test_mma_memory_addressing;
    logic        clk = 1'b0;
    logic        reset = 1'b1;
    logic [11:0] pc = 12'h000;
    logic [11:0] ret_pc = 12'h000;
    logic [11:0] call_target = 12'h000;
    logic        call_req = 1'b0;
    logic        sub_exit = 1'b0;
    logic        interrupt_exit = 1'b0;
    logic        timer_irq = 1'b0;
    logic        adc_irq = 1'b0;
    logic        pc_load_q, timer_ack_q, adc_ack_q, stack_full, table_busy, prog_rd;
    logic [11:0] pc_target_q, prog_addr_q;
    logic        rd_cur = 1'b0;
    logic        rd_last = 1'b0;
    logic [7:0]  table_dst = 8'h00;
    logic [14:0] prog_data = 15'h0000;
    logic [7:0]  dm_addr = 8'h00;
    logic        dm_rd = 1'b0;
    logic        dm_wr = 1'b0;
    logic [7:0]  dm_wdata = 8'h00;
    logic        bset = 1'b0;
    logic        bclr = 1'b0;
    logic [2:0]  bit_idx = 3'h0;
    logic [7:0]  dm_rdata_q;
    int          err_total = 0;
    int          cmp_count = 0;

    always #50 clk = ~clk;

    mma_memory_addressing u_mma_memory_addressing (
        .clk(clk), .reset(reset), .pc(pc), .ret_pc(ret_pc), .call_req(call_req),
        .call_target(call_target), .sub_exit(sub_exit), .interrupt_exit(interrupt_exit),
        .timer_irq(timer_irq), .adc_irq(adc_irq), .pc_load_q(pc_load_q), .pc_target_q(pc_target_q),
        .timer_ack_q(timer_ack_q), .adc_ack_q(adc_ack_q), .stack_full(stack_full),
        .table_read_current_page(rd_cur), .table_read_last_page(rd_last), .table_dst(table_dst),
        .table_busy(table_busy), .prog_rd(prog_rd), .prog_addr_q(prog_addr_q), .prog_data(prog_data),
        .dm_addr(dm_addr), .dm_rd(dm_rd), .dm_wr(dm_wr), .dm_wdata(dm_wdata),
        .bit_set_instruction(bset), .bit_clear_instruction(bclr), .bit_idx(bit_idx),
        .dm_rdata_q(dm_rdata_q)
    );

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [11:0] got, input logic [11:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic close_out();
        $display("compares %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        dm_addr <= a;
        dm_wr <= 1'b1;
        dm_wdata <= d;
        @(posedge clk);
        dm_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        dm_addr <= a;
        dm_rd <= 1'b1;
        @(posedge clk);
        dm_rd <= 1'b0;
        #1;
        chk({4'h0, dm_rdata_q}, {4'h0, exp});
    endtask

    task automatic bitop(input logic set, input logic [2:0] i);
        @(posedge clk);
        dm_addr <= 8'h30;
        bit_idx <= i;
        bset <= set;
        bclr <= ~set;
        @(posedge clk);
        bset <= 1'b0;
        bclr <= 1'b0;
    endtask

    // last page when lp is set; word is valid from the start edge through the fetch
    task automatic tbl(input logic lp, input logic [11:0] p, input logic [7:0] d,
                       input logic [14:0] w, input logic [11:0] exp);
        @(posedge clk);
        rd_last <= lp;
        rd_cur <= ~lp;
        pc <= p;
        table_dst <= d;
        prog_data <= w;
        @(posedge clk);
        rd_last <= 1'b0;
        rd_cur <= 1'b0;
        #1;
        chk(prog_addr_q, exp);
        chk({10'h0, table_busy, prog_rd}, 12'h003);
        @(posedge clk);
        #1;
        chk({11'h0, table_busy}, 12'h000);
    endtask

    task automatic flow(input logic c, input logic s, input logic i, input logic [11:0] r,
                        input logic [11:0] exp);
        @(posedge clk);
        call_req <= c;
        sub_exit <= s;
        interrupt_exit <= i;
        ret_pc <= r;
        call_target <= r + 12'h400;
        @(posedge clk);
        call_req <= 1'b0;
        sub_exit <= 1'b0;
        interrupt_exit <= 1'b0;
        #1;
        chk({11'h0, pc_load_q}, 12'h001);
        chk(pc_target_q, exp);
    endtask

    task automatic irq(input logic t, input logic a, input logic [11:0] r, input logic [11:0] exp);
        @(posedge clk);
        timer_irq <= t;
        adc_irq <= a;
        ret_pc <= r;
        @(posedge clk);
        timer_irq <= 1'b0;
        adc_irq <= 1'b0;
        #1;
        chk({9'h0, pc_load_q, timer_ack_q, adc_ack_q}, {9'h0, 1'b1, t, ~t});
        chk(pc_target_q, exp);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (5000) @(posedge clk);
        err_total++;
        close_out();
    end

    initial begin
        repeat (10) @(posedge clk);
        reset <= 1'b0;
        #1;
        chk({11'h0, stack_full}, 12'h000);
        wr(8'h30, 8'h5a);
        rd(8'h30, 8'h5a);
        rd(8'h05, 8'h00);
        rd(8'h27, 8'h00);
        wr(8'h08, 8'hff);
        rd(8'h08, 8'h00);
        wr(8'h07, 8'h10);
        rd(8'h07, 8'h10);
        wr(8'h50, 8'h11);
        wr(8'h04, 8'h01);
        wr(8'h03, 8'h50);
        wr(8'h02, 8'h22);
        rd(8'h50, 8'h11);
        rd(8'h02, 8'h22);
        wr(8'h03, 8'h90);
        rd(8'h02, 8'h00);
        wr(8'h03, 8'h30);
        rd(8'h02, 8'h5a);
        wr(8'h04, 8'h00);
        wr(8'h03, 8'h50);
        rd(8'h02, 8'h11);
        wr(8'h01, 8'h30);
        rd(8'h00, 8'h5a);
        wr(8'h00, 8'h77);
        rd(8'h30, 8'h77);
        wr(8'h01, 8'h02);
        rd(8'h00, 8'h00);
        wr(8'h00, 8'hff);
        rd(8'h50, 8'h11);
        bitop(1'b1, 3'h3);
        bitop(1'b0, 3'h0);
        rd(8'h30, 8'h7e);
        // no interrupt pending around table reads
        tbl(1'b1, 12'h3a5, 8'h28, 15'h2abc, 12'hf10);
        rd(8'h28, 8'hbc);
        rd(8'h08, 8'h2a);
        wr(8'h07, 8'hc4);
        tbl(1'b0, 12'h3a5, 8'h29, 15'h1357, 12'h3c4);
        rd(8'h29, 8'h57);
        rd(8'h08, 8'h13);
        irq(1'b1, 1'b0, 12'h050, 12'h008);
        flow(1'b0, 1'b0, 1'b1, 12'h000, 12'h050);
        irq(1'b0, 1'b1, 12'h051, 12'h00c);
        irq(1'b1, 1'b1, 12'h052, 12'h008);
        flow(1'b0, 1'b1, 1'b0, 12'h000, 12'h052);
        flow(1'b0, 1'b0, 1'b1, 12'h000, 12'h051);
        for (int k = 1; k <= 7; k++)
            flow(1'b1, 1'b0, 1'b0, 12'h100 + 12'(k), 12'h500 + 12'(k));
        chk({11'h0, stack_full}, 12'h001);
        // full stack holds the interrupt off until a return frees a level
        @(posedge clk);
        timer_irq <= 1'b1;
        ret_pc <= 12'h2aa;
        repeat (3) begin
            @(posedge clk);
            #1;
            chk({11'h0, pc_load_q}, 12'h000);
        end
        @(posedge clk);
        sub_exit <= 1'b1;
        @(posedge clk);
        sub_exit <= 1'b0;
        #1;
        chk(pc_target_q, 12'h107);
        @(posedge clk);
        timer_irq <= 1'b0;
        #1;
        chk({10'h0, pc_load_q, timer_ack_q}, 12'h003);
        chk(pc_target_q, 12'h008);
        flow(1'b0, 1'b0, 1'b1, 12'h000, 12'h2aa);
        for (int k = 6; k >= 2; k--)
            flow(1'b0, 1'b1, 1'b0, 12'h000, 12'h100 + 12'(k));
        #1;
        chk({11'h0, stack_full}, 12'h000);
        close_out();
    end
endmodule

// File: src/mma_memory_addressing.sv
`timescale 1ns/1ps

module mma_memory_addressing #(
    parameter int PC_W = mma_pkg::MMA_PC_W,
    parameter int PW   = mma_pkg::MMA_PROG_W
) (
    // clock and reset
    input  wire logic            clk,
    input  wire logic            reset,
    // program flow from the core
    input  wire logic [PC_W-1:0] pc,
    input  wire logic [PC_W-1:0] ret_pc,
    input  wire logic            call_req,
    input  wire logic [PC_W-1:0] call_target,
    input  wire logic            sub_exit,
    input  wire logic            interrupt_exit,
    // enabled pending interrupts
    input  wire logic            timer_irq,
    input  wire logic            adc_irq,
    // program counter load
    output logic                 pc_load_q,
    output logic      [PC_W-1:0] pc_target_q,
    output logic                 timer_ack_q,
    output logic                 adc_ack_q,
    output logic                 stack_full,
    // table read
    input  wire logic            table_read_current_page,
    input  wire logic            table_read_last_page,
    input  wire logic [7:0]      table_dst,
    output logic                 table_busy,
    output logic                 prog_rd,
    output logic      [PC_W-1:0] prog_addr_q,
    input  wire logic [PW-1:0]   prog_data,
    // data memory access
    input  wire logic [7:0]      dm_addr,
    input  wire logic            dm_rd,
    input  wire logic            dm_wr,
    input  wire logic [7:0]      dm_wdata,
    input  wire logic            bit_set_instruction,
    input  wire logic            bit_clear_instruction,
    input  wire logic [2:0]      bit_idx,
    output logic      [7:0]      dm_rdata_q
);

    mma_pkg::mma_tr_state_t tr_state_q;

    logic [7:0]      mem_pointer_0_q;
    logic [7:0]      mem_pointer_1_q;
    logic [7:0]      bank_select_q;
    logic [7:0]      table_pointer_q;
    logic [7:0]      table_high_byte_q;
    logic [7:0]      tr_dst_q;
    logic [7:0]      ram0_q [mma_pkg::MMA_BANK0_WORDS];
    logic [7:0]      ram1_q [mma_pkg::MMA_BANK1_WORDS];

    logic            fetch;
    logic [7:0]      acc_addr;
    logic            is_ind0;
    logic            is_ind1;
    logic [7:0]      eff_addr;
    logic            bank1;
    logic            self_ind;
    logic            hit_ram0;
    logic            hit_ram1;
    logic [7:0]      ram0_idx;
    logic [7:0]      rd_val;
    logic [7:0]      bit_mask;
    logic            wr_en;
    logic [7:0]      wr_val;

    logic            do_ret;
    logic            do_call;
    logic            do_ack;
    logic            tr_start;
    logic [PC_W-1:0] stack_top;
    logic            stack_empty;
    logic [PC_W-9:0] pc_page;

    ////////////////////////////////////////////////////////////////////////////
    // access decode

    assign fetch      = (tr_state_q == mma_pkg::MMA_TR_FETCH);
    assign table_busy = fetch;
    assign prog_rd    = fetch;
    assign pc_page    = pc[PC_W-1:8];

    // the table write borrows the single memory port in its second cycle
    assign acc_addr = fetch ? tr_dst_q : dm_addr;
    assign is_ind0  = (acc_addr == mma_pkg::MMA_ADDR_IND0);
    assign is_ind1  = (acc_addr == mma_pkg::MMA_ADDR_IND1);

    always_comb begin
        if (is_ind0) begin
            eff_addr = mem_pointer_0_q;
        end else if (is_ind1) begin
            eff_addr = mem_pointer_1_q;
        end else begin
            eff_addr = acc_addr;
        end
    end

    assign bank1 = is_ind1 && (bank_select_q == mma_pkg::MMA_BANK1_SELECT);

    assign self_ind = (is_ind0 || is_ind1)
                    && (eff_addr == mma_pkg::MMA_ADDR_IND0 || eff_addr == mma_pkg::MMA_ADDR_IND1);

    assign hit_ram1 = !self_ind && bank1
                    && eff_addr >= mma_pkg::MMA_BANK1_START && eff_addr <= mma_pkg::MMA_BANK1_END;
    assign hit_ram0 = !self_ind && eff_addr >= mma_pkg::MMA_GP_START
                    && !(bank1 && eff_addr >= mma_pkg::MMA_BANK1_START);
    assign ram0_idx = eff_addr - mma_pkg::MMA_GP_START;

    always_comb begin
        rd_val = mma_pkg::MMA_READ_NULL;
        if (self_ind) begin
            rd_val = mma_pkg::MMA_READ_NULL;
        end else if (hit_ram1) begin
            rd_val = ram1_q[eff_addr[5:0]];
        end else if (hit_ram0) begin
            rd_val = ram0_q[ram0_idx];
        end else begin
            // no stack location in the map
            unique case (eff_addr)
                mma_pkg::MMA_ADDR_MP0:      rd_val = mem_pointer_0_q;
                mma_pkg::MMA_ADDR_MP1:      rd_val = mem_pointer_1_q;
                mma_pkg::MMA_ADDR_BANK_SEL: rd_val = bank_select_q;
                mma_pkg::MMA_ADDR_TABLE_POINTER:     rd_val = table_pointer_q;
                mma_pkg::MMA_ADDR_TABLE_HIGH_BYTE:     rd_val = table_high_byte_q;
                default:                    rd_val = mma_pkg::MMA_READ_NULL;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // write path

    assign bit_mask = 8'h01 << bit_idx;
    assign wr_en    = fetch || dm_wr || bit_set_instruction || bit_clear_instruction;

    always_comb begin
        if (fetch) begin
            wr_val = prog_data[7:0];
        end else if (bit_set_instruction) begin
            wr_val = rd_val | bit_mask;
        end else if (bit_clear_instruction) begin
            wr_val = rd_val & ~bit_mask;
        end else begin
            wr_val = dm_wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (wr_en && hit_ram0) begin
            ram0_q[ram0_idx] <= wr_val;
        end
        if (wr_en && hit_ram1) begin
            ram1_q[eff_addr[5:0]] <= wr_val;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            mem_pointer_0_q <= mma_pkg::MMA_RST_MP;
            mem_pointer_1_q <= mma_pkg::MMA_RST_MP;
            bank_select_q   <= mma_pkg::MMA_RST_BANK_SEL;
            table_pointer_q <= mma_pkg::MMA_RST_TABLE_POINTER;
        end else if (wr_en && !self_ind) begin
            unique case (eff_addr)
                mma_pkg::MMA_ADDR_MP0:      mem_pointer_0_q <= wr_val;
                mma_pkg::MMA_ADDR_MP1:      mem_pointer_1_q <= wr_val;
                mma_pkg::MMA_ADDR_BANK_SEL: bank_select_q   <= wr_val;
                mma_pkg::MMA_ADDR_TABLE_POINTER:     table_pointer_q <= wr_val;
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            dm_rdata_q <= mma_pkg::MMA_READ_NULL;
        end else if (dm_rd) begin
            dm_rdata_q <= rd_val;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // table read

    // requests during the fetch cycle are ignored; the core waits on busy
    assign tr_start = !fetch && (table_read_current_page || table_read_last_page);

    always_ff @(posedge clk) begin
        if (reset) begin
            tr_state_q <= mma_pkg::MMA_TR_IDLE;
        end else begin
            unique case (tr_state_q)
                mma_pkg::MMA_TR_IDLE:  tr_state_q <= tr_start ? mma_pkg::MMA_TR_FETCH : mma_pkg::MMA_TR_IDLE;
                mma_pkg::MMA_TR_FETCH: tr_state_q <= mma_pkg::MMA_TR_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            prog_addr_q <= '0;
            tr_dst_q    <= '0;
        end else if (tr_start) begin
            tr_dst_q <= table_dst;
            if (table_read_last_page) begin
                prog_addr_q <= {{(PC_W - 8){1'b1}}, table_pointer_q};
            end else begin
                prog_addr_q <= {pc_page, table_pointer_q};
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            table_high_byte_q <= mma_pkg::MMA_RST_TABLE_HIGH_BYTE;
        // only the table read loads it
        end else if (fetch) begin
            table_high_byte_q <= 8'(prog_data[PW-1:8]);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // return stack and vectors

    // push on call or acknowledge, pop on return
    assign do_ret  = sub_exit || interrupt_exit;
    assign do_call = call_req && !do_ret;
    assign do_ack  = (timer_irq || adc_irq) && !stack_full && !do_ret && !do_call;

    mma_return_stack #(
        .DEPTH (mma_pkg::MMA_STACK_DEPTH),
        .W     (PC_W)
    ) u_stack (
        .clk       (clk),
        .reset     (reset),
        .push      (do_call || do_ack),
        .pop       (do_ret),
        .push_data (ret_pc),
        .top_data  (stack_top),
        .full      (stack_full),
        .empty     (stack_empty)
    );

    always_ff @(posedge clk) begin
        if (reset) begin
            pc_load_q   <= 1'b0;
            pc_target_q <= '0;
            timer_ack_q <= 1'b0;
            adc_ack_q   <= 1'b0;
        end else begin
            pc_load_q   <= do_ret || do_call || do_ack;
            timer_ack_q <= do_ack && timer_irq;
            adc_ack_q   <= do_ack && !timer_irq;
            if (do_ret) begin
                pc_target_q <= stack_top;
            end else if (do_call) begin
                pc_target_q <= call_target;
            end else if (do_ack && timer_irq) begin
                pc_target_q <= PC_W'(mma_pkg::MMA_VEC_TIMER);
            end else if (do_ack) begin
                pc_target_q <= PC_W'(mma_pkg::MMA_VEC_ADC);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks

    chk_timer_vector: assert property (@(posedge clk) disable iff (reset)
        timer_irq && !stack_full && !call_req && !sub_exit && !interrupt_exit
        |=> timer_ack_q && pc_load_q && pc_target_q == PC_W'(mma_pkg::MMA_VEC_TIMER))
        else $error("timer interrupt not sent to its vector");

    chk_adc_vector: assert property (@(posedge clk) disable iff (reset)
        adc_ack_q |-> pc_load_q && pc_target_q == PC_W'(mma_pkg::MMA_VEC_ADC) && !timer_ack_q)
        else $error("converter interrupt not sent to its vector");

    chk_current_page: assert property (@(posedge clk) disable iff (reset)
        tr_start && !table_read_last_page
        |=> prog_addr_q == {$past(pc_page), $past(table_pointer_q)})
        else $error("current page table address wrong");

    chk_last_page: assert property (@(posedge clk) disable iff (reset)
        tr_start && table_read_last_page
        |=> prog_addr_q == {{(PC_W - 8){1'b1}}, $past(table_pointer_q)})
        else $error("last page table address wrong");

    chk_high_byte_load: assert property (@(posedge clk) disable iff (reset)
        fetch |=> table_high_byte_q == 8'($past(prog_data[PW-1:8])))
        else $error("high byte not taken from program word");

    chk_high_byte_hold: assert property (@(posedge clk) disable iff (reset)
        !fetch |=> $stable(table_high_byte_q))
        else $error("high byte changed outside a table read");

    chk_two_cycle_read: assert property (@(posedge clk) disable iff (reset)
        tr_start |=> prog_rd ##1 !prog_rd)
        else $error("table read did not take two cycles");

    chk_full_withhold: assert property (@(posedge clk) disable iff (reset)
        stack_full && !do_ret |=> !timer_ack_q && !adc_ack_q)
        else $error("interrupt acknowledged on full stack");

    chk_reset_empty: assert property (@(posedge clk)
        reset |=> stack_empty && !stack_full)
        else $error("stack not empty after reset");

    chk_self_ind_zero: assert property (@(posedge clk) disable iff (reset)
        dm_rd && self_ind |=> dm_rdata_q == mma_pkg::MMA_READ_NULL)
        else $error("self indirect read not zero");

    chk_unimpl_zero: assert property (@(posedge clk) disable iff (reset)
        dm_rd && !fetch && !is_ind0 && !is_ind1 && dm_addr < mma_pkg::MMA_GP_START
        && dm_addr != mma_pkg::MMA_ADDR_MP0 && dm_addr != mma_pkg::MMA_ADDR_MP1
        && dm_addr != mma_pkg::MMA_ADDR_BANK_SEL && dm_addr != mma_pkg::MMA_ADDR_TABLE_POINTER
        && dm_addr != mma_pkg::MMA_ADDR_TABLE_HIGH_BYTE |=> dm_rdata_q == mma_pkg::MMA_READ_NULL)
        else $error("unimplemented address read not zero");

    cov_table_last: cover property (@(posedge clk) disable iff (reset)
        tr_start && table_read_last_page ##1 fetch);

    cov_full_then_ret: cover property (@(posedge clk) disable iff (reset)
        stack_full && timer_irq && do_ret ##1 timer_irq ##1 timer_ack_q);

    cov_bank1_write: cover property (@(posedge clk) disable iff (reset)
        dm_wr && hit_ram1);

endmodule

// File: src/mma_pkg.sv
package mma_pkg;

    // data memory map
    localparam logic [7:0] MMA_ADDR_IND0      = 8'h00;
    localparam logic [7:0] MMA_ADDR_MP0       = 8'h01;
    localparam logic [7:0] MMA_ADDR_IND1      = 8'h02;
    localparam logic [7:0] MMA_ADDR_MP1       = 8'h03;
    localparam logic [7:0] MMA_ADDR_BANK_SEL  = 8'h04;
    localparam logic [7:0] MMA_ADDR_TABLE_POINTER      = 8'h07;
    localparam logic [7:0] MMA_ADDR_TABLE_HIGH_BYTE      = 8'h08;
    localparam logic [7:0] MMA_GP_START       = 8'h28;
    localparam logic [7:0] MMA_BANK1_START    = 8'h40;
    localparam logic [7:0] MMA_BANK1_END      = 8'h7f;
    localparam int         MMA_BANK0_WORDS    = 216;
    localparam int         MMA_BANK1_WORDS    = 64;
    localparam logic [7:0] MMA_BANK1_SELECT   = 8'h01;
    localparam logic [7:0] MMA_READ_NULL      = 8'h00;

    // reset values
    localparam logic [7:0] MMA_RST_MP         = 8'h00;
    localparam logic [7:0] MMA_RST_BANK_SEL   = 8'h00;
    localparam logic [7:0] MMA_RST_TABLE_POINTER       = 8'h00;
    localparam logic [7:0] MMA_RST_TABLE_HIGH_BYTE       = 8'h00;

    // program memory
    localparam int         MMA_PC_W           = 12;
    localparam int         MMA_PROG_W         = 15;
    localparam logic [11:0] MMA_VEC_TIMER     = 12'h008;
    localparam logic [11:0] MMA_VEC_ADC       = 12'h00c;
    localparam int         MMA_STACK_DEPTH    = 6;

    typedef enum logic [0:0] {
        MMA_TR_IDLE  = 1'b0,
        MMA_TR_FETCH = 1'b1
    } mma_tr_state_t;

endpackage

// File: src/mma_return_stack.sv
`timescale 1ns/1ps

module mma_return_stack #(
    parameter int DEPTH = mma_pkg::MMA_STACK_DEPTH,
    parameter int W     = mma_pkg::MMA_PC_W
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         reset,
    // push and pop
    input  wire logic         push,
    input  wire logic         pop,
    input  wire logic [W-1:0] push_data,
    // state
    output logic      [W-1:0] top_data,
    output logic              full,
    output logic              empty
);

    localparam int IW = $clog2(DEPTH);

    logic [W-1:0]  entry_q [DEPTH];
    logic [IW-1:0] top_q;
    logic [IW:0]   count_q;
    logic [IW-1:0] next_idx;
    logic [IW-1:0] prev_idx;

    // circular storage: a push on a full stack overwrites the oldest entry
    assign next_idx = (top_q == IW'(DEPTH - 1)) ? '0 : top_q + 1'b1;
    assign prev_idx = (top_q == '0) ? IW'(DEPTH - 1) : top_q - 1'b1;
    assign full     = (count_q == (IW + 1)'(DEPTH));
    assign empty    = (count_q == '0);
    assign top_data = entry_q[top_q];

    always_ff @(posedge clk) begin
        if (push) begin
            entry_q[next_idx] <= push_data;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            top_q   <= IW'(DEPTH - 1);
            count_q <= '0;
        end else if (push) begin
            top_q <= next_idx;
            if (!full) begin
                count_q <= count_q + 1'b1;
            end
        end else if (pop && !empty) begin
            top_q   <= prev_idx;
            count_q <= count_q - 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////

    chk_full_stays_full: assert property (@(posedge clk) disable iff (reset)
        full && push && !pop |=> full && top_q == $past(next_idx))
        else $error("push on full stack lost the full state");

endmodule
